/* File: core/mps_pkg.sv */
// Package with the constants, states and carriers of the module power sequencer.
package mps_pkg;

  // Clock rate in kHz (40 MHz reference clock).
  localparam int unsigned CLK_KHZ = 40000;

  // Least hold time of the power-on request for a clean switch-on, in ms.
  localparam int unsigned PON_HOLD_MS = 300;
  // The same time in clock cycles, an exact product of ms and kHz.
  localparam int unsigned PON_HOLD_CYC = PON_HOLD_MS * CLK_KHZ;

  // Default spacing between regulator enables, in clock cycles.
  localparam int unsigned REG_STEP_CYC = 64;
  // Default hold time of the internal baseband reset, in clock cycles.
  localparam int unsigned RST_HOLD_CYC = 256;
  // Fixed spacing between interface configuration steps, in clock cycles.
  localparam int unsigned CFG_STEP_CYC = 4;

  // Number of internal regulators and of digital interface groups.
  localparam int unsigned NUM_REG = 4;
  localparam int unsigned NUM_IF  = 4;

  // Width of the shared step timer.
  localparam int unsigned TMR_W = 32;

  // Reset values of the regulator enable and interface configuration outputs.
  localparam logic [NUM_REG-1:0] REG_EN_RST  = 4'h0;
  localparam logic [NUM_IF-1:0]  IF_CFG_RST  = 4'h0;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_NO_SUPPLY,
    ST_OFF,
    ST_REG_UP,
    ST_CORE_RST,
    ST_IF_CFG,
    ST_READY,
    ST_SAVE,
    ST_DETACH,
    ST_SW_RST
  } mps_state_type;

  // Supply supervisor comparator outputs.
  typedef struct packed {
    logic above_min;  // Supply at or above the operating minimum.
    logic below_low;  // Supply below the lower threshold.
  } mps_supply_type;

  // Commands from the firmware command interpreter, one-cycle pulses.
  typedef struct packed {
    logic power_off_command;
    logic function_control_command;
  } mps_cmd_type;

  // Handshake with the firmware for the orderly power-off.
  typedef struct packed {
    logic save_done;
    logic detach_done;
  } mps_ack_type;

endpackage

/* File: core/mps_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module mps_sync
  import mps_pkg::*;
#(
  parameter int unsigned WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // First stage; read only by the second stage.
  logic [WIDTH-1:0] meta_q;

  // Both stages reset to the idle level so no false edge appears after reset.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* File: core/mps_sequencer.sv */
// Power-state sequencer: switch-on, ordered power-up, switch-off and resets.
`timescale 1ns/1ps
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int unsigned REG_STEP = REG_STEP_CYC,  // Regulator step spacing, in cycles.
  parameter int unsigned RST_HOLD = RST_HOLD_CYC   // Internal reset hold, in cycles.
)
(
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               power_on_request_n_i,
  input  wire mps_supply_type     supply_i,
  input  wire logic               ext_reset_n_i,
  input  wire mps_cmd_type        cmd_i,
  input  wire mps_ack_type        ack_i,
  output logic                    pon_pullup_en_o,
  output logic [NUM_REG-1:0]      reg_en_o,
  output logic                    core_reset_n_o,
  output logic                    pins_tristate_o,
  output logic [NUM_IF-1:0]       if_cfg_o,
  output logic                    ready_o,
  output logic                    save_req_o,
  output logic                    detach_req_o,
  output logic                    pon_held_o
);

  // Synchronised pin levels and supervisor flags.
  logic           pon_n_s;       // Request line, synchronised.
  logic           ext_rst_n_s;   // External reset pin, synchronised.
  mps_supply_type supply_s;      // Supervisor flags, synchronised.
  logic           pon_n_prev_q;  // Previous request level for edge detection.
  logic           armed_q;       // Supply has been seen below the lower threshold.
  logic           pon_fall;      // One-cycle falling edge of the request.
  logic           vcc_start;     // Supply rise start event.
  logic [3:0]     pins_s;        // Synchronised bank: request, external reset, supervisor pair.

  mps_state_type  state_q;       // Sequencer state.
  logic [TMR_W-1:0] tmr_q;       // Step timer, counts down.
  logic [2:0]     idx_q;         // Current regulator or interface index.
  logic [TMR_W-1:0] hold_q;      // Request low-time counter, saturating.

  // One synchroniser bank for all pin levels. Request and reset pins idle high; the
  // supervisor pair resets to "below low" so a later supply rise is seen as such.
  mps_sync #(.WIDTH(4), .RST_VAL(4'hd)) u_sync_pins
  (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   ({power_on_request_n_i, ext_reset_n_i, supply_i}),
    .sync_o    (pins_s)
  );
  assign pon_n_s     = pins_s[3];
  assign ext_rst_n_s = pins_s[2];
  assign supply_s    = pins_s[1:0];

  // Edge and supply-rise detection, all on synchronised levels.
  assign pon_fall  = pon_n_prev_q & ~pon_n_s;
  assign vcc_start = armed_q & supply_s.above_min & ~pon_n_s;

  // Previous request level.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      pon_n_prev_q <= 1'b1;
    else
      pon_n_prev_q <= pon_n_s;
  end

  // Arm the supply-rise start at reset and after the supply dipped below the lower threshold.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      armed_q <= 1'b1;
    else if (supply_s.below_low)
      armed_q <= 1'b1;
    else if (supply_s.above_min)
      armed_q <= 1'b0;
  end

  // Low-time counter on the request line; a status aid for the host side.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      hold_q     <= '0;
      pon_held_o <= 1'b0;
    end
    else if (pon_n_s)
    begin
      hold_q     <= '0;
      pon_held_o <= 1'b0;
    end
    else
    begin
      if (hold_q != TMR_W'(PON_HOLD_CYC))
        hold_q <= hold_q + TMR_W'(1);
      pon_held_o <= (hold_q == TMR_W'(PON_HOLD_CYC));
    end
  end

  // Main sequencer. Supply loss overrides every state, hardware reset every state but no-supply and off; the
  // supply loss path skips save and detach on purpose, as there is no time.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_NO_SUPPLY;
      tmr_q   <= '0;
      idx_q   <= '0;
    end
    else if (supply_s.below_low)
    begin
      state_q <= ST_NO_SUPPLY;
      tmr_q   <= '0;
      idx_q   <= '0;
    end
    else if (!ext_rst_n_s && state_q != ST_NO_SUPPLY && state_q != ST_OFF)
    begin
      state_q <= ST_CORE_RST;
      tmr_q   <= TMR_W'(RST_HOLD);
      idx_q   <= '0;
    end
    else
    begin
      if (tmr_q != '0)
        tmr_q <= tmr_q - TMR_W'(1);
      case (state_q)
        // Waiting for a valid supply with the request held low.
        ST_NO_SUPPLY:
        begin
          if (vcc_start)
          begin
            state_q <= ST_REG_UP;
            tmr_q   <= TMR_W'(REG_STEP);
            idx_q   <= '0;
          end
          else if (supply_s.above_min && !armed_q)
            state_q <= ST_OFF;
        end
        // Powered but off; only a request falling edge wakes the module.
        ST_OFF:
        begin
          if (pon_fall)
          begin
            state_q <= ST_REG_UP;
            tmr_q   <= TMR_W'(REG_STEP);
            idx_q   <= '0;
          end
        end
        // Regulators come up one by one, spaced by the step parameter.
        ST_REG_UP:
        begin
          if (tmr_q == '0)
          begin
            if (idx_q == 3'(NUM_REG - 1))
            begin
              state_q <= ST_CORE_RST;
              tmr_q   <= TMR_W'(RST_HOLD);
              idx_q   <= '0;
            end
            else
            begin
              idx_q <= idx_q + 3'h1;
              tmr_q <= TMR_W'(REG_STEP);
            end
          end
        end
        // Core held in reset for the hold interval.
        ST_CORE_RST:
        begin
          if (tmr_q == '0)
          begin
            state_q <= ST_IF_CFG;
            tmr_q   <= TMR_W'(CFG_STEP_CYC);
            idx_q   <= '0;
          end
        end
        // Interfaces leave their reset state one at a time.
        ST_IF_CFG:
        begin
          if (tmr_q == '0)
          begin
            if (idx_q == 3'(NUM_IF - 1))
              state_q <= ST_READY;
            else
            begin
              idx_q <= idx_q + 3'h1;
              tmr_q <= TMR_W'(CFG_STEP_CYC);
            end
          end
        end
        // Running; the request line is not looked at here.
        ST_READY:
          if (cmd_i.power_off_command)
            state_q <= ST_SAVE;
          else if (cmd_i.function_control_command)
            state_q <= ST_SW_RST;
        // Settings are written to non-volatile storage first.
        ST_SAVE:
          if (ack_i.save_done)
            state_q <= ST_DETACH;
        // Then the network detach; off once the firmware confirms it.
        ST_DETACH:
          if (ack_i.detach_done)
            state_q <= ST_OFF;
        // Software reset re-enters the core reset hold with regulators kept up.
        ST_SW_RST:
        begin
          state_q <= ST_CORE_RST;
          tmr_q   <= TMR_W'(RST_HOLD);
          idx_q   <= '0;
        end
        default:
          state_q <= ST_NO_SUPPLY;
      endcase
    end
  end

  // Registered outputs decoded from the current state, so they follow it one cycle later.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      reg_en_o        <= REG_EN_RST;
      core_reset_n_o  <= 1'b0;
      pins_tristate_o <= 1'b1;
      if_cfg_o        <= IF_CFG_RST;
      ready_o         <= 1'b0;
      save_req_o      <= 1'b0;
      detach_req_o    <= 1'b0;
      pon_pullup_en_o <= 1'b1;
    end
    else
    begin
      pon_pullup_en_o <= 1'b1;
      save_req_o      <= (state_q == ST_SAVE);
      detach_req_o    <= (state_q == ST_DETACH);
      ready_o         <= (state_q == ST_READY);
      // Software reset pulls the core reset at once, not after a step.
      core_reset_n_o  <= (state_q == ST_IF_CFG) || (state_q == ST_READY) ||
                         (state_q == ST_SAVE) || (state_q == ST_DETACH);
      // Pins float while off or while regulators ramp.
      pins_tristate_o <= (state_q == ST_NO_SUPPLY) || (state_q == ST_OFF) ||
                         (state_q == ST_REG_UP);
      case (state_q)
        ST_REG_UP:
        begin
          for (int i = 0; i < NUM_REG; i++)
            reg_en_o[i] <= (3'(i) <= idx_q);
          if_cfg_o <= IF_CFG_RST;
        end
        ST_CORE_RST, ST_SW_RST:
        begin
          reg_en_o <= {NUM_REG{1'b1}};
          if_cfg_o <= IF_CFG_RST;
        end
        ST_IF_CFG:
        begin
          reg_en_o <= {NUM_REG{1'b1}};
          for (int i = 0; i < NUM_IF; i++)
            if_cfg_o[i] <= (3'(i) < idx_q) || (3'(i) == idx_q && tmr_q == '0);
        end
        ST_READY, ST_SAVE, ST_DETACH:
        begin
          reg_en_o <= {NUM_REG{1'b1}};
          if_cfg_o <= {NUM_IF{1'b1}};
        end
        default:
        begin
          reg_en_o <= REG_EN_RST;
          if_cfg_o <= IF_CFG_RST;
        end
      endcase
    end
  end

endmodule

/* File: tb/mps_seq_properties.sv */
// Checker of the power sequencer ordering rules, bound to the sequencer.
`timescale 1ns/1ps
module mps_seq_properties
  import mps_pkg::*;
(
  input wire logic               ref_clk_i,
  input wire logic               rst_i,
  input wire mps_supply_type     supply_i,
  input wire mps_ack_type        ack_i,
  input wire logic               pon_pullup_en_o,
  input wire logic [NUM_REG-1:0] reg_en_o,
  input wire logic               core_reset_n_o,
  input wire logic               pins_tristate_o,
  input wire logic [NUM_IF-1:0]  if_cfg_o,
  input wire logic               ready_o,
  input wire logic               save_req_o,
  input wire logic               detach_req_o
);
  // One clock domain, so clock and reset are given once for all properties.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_pullup_on: assert property (pon_pullup_en_o)
    else $error("request pull-up disabled");
  a_reg_order: assert property (reg_en_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("regulators enabled out of order");
  a_pins_float: assert property (reg_en_o != 4'hf |-> pins_tristate_o)
    else $error("pins driven before all regulators are up");
  a_core_held: assert property (core_reset_n_o |-> reg_en_o == 4'hf)
    else $error("core reset released with a regulator off");
  a_cfg_after: assert property (if_cfg_o != 4'h0 |-> core_reset_n_o && if_cfg_o inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("interface configured out of sequence");
  a_ready_last: assert property (ready_o |-> if_cfg_o == 4'hf && !pins_tristate_o)
    else $error("ready before configuration finished");
  a_save_first: assert property ($rose(save_req_o) |-> !detach_req_o && ($past(ready_o) || $past(ready_o, 2)))
    else $error("save started outside ready");
  a_detach_next: assert property ($rose(detach_req_o) |-> $past(save_req_o) || $past(save_req_o, 2))
    else $error("detach without a save before it");
  a_off_after: assert property (detach_req_o && ack_i.detach_done |-> ##[1:4] (reg_en_o == 4'h0 && pins_tristate_o))
    else $error("no switch-off after detach");
  a_loss_quiet: assert property (supply_i.below_low [*6] |-> reg_en_o == 4'h0 && !save_req_o && !detach_req_o)
    else $error("supply loss not handled as plain shutdown");
endmodule

bind mps_sequencer mps_seq_properties chk_u (.ref_clk_i, .rst_i, .supply_i, .ack_i, .pon_pullup_en_o, .reg_en_o,
  .core_reset_n_o, .pins_tristate_o, .if_cfg_o, .ready_o, .save_req_o, .detach_req_o);

/* File: tb/mps_host_model.sv */
// Host model: open-drain driver of the power-on request line.
`timescale 1ns/1ps
module mps_host_model
#(
  parameter int unsigned HOLD = 20  // Shortened hold of the request after a press, in cycles.
)
(
  input  wire logic ref_clk_i,
  input  wire logic press_i,
  input  wire logic pullup_en_i,
  output logic      request_n_o
);
  int unsigned hold_q = 0;  // Cycles the line is still kept low after a press.

  // A press is stretched so switch-on completes, then the line is let go to save current.
  always_ff @(posedge ref_clk_i)
    if (press_i)
      hold_q <= HOLD;
    else if (hold_q != 0)
      hold_q <= hold_q - 1;

  // The host only pulls low; a released line follows the device pull-up, else floats.
  assign request_n_o = (press_i || hold_q != 0) ? 1'b0 : (pullup_en_i ? 1'b1 : 1'bz);
endmodule

/* File: tb/mps_sequencer_bench.sv */
// Self-checking bench of the module power sequencer.
`timescale 1ns/1ps
module mps_sequencer_bench
  import mps_pkg::*;
  ;
  logic               ref_clk_i     = 1'b0;
  logic               rst_i         = 1'b1;
  logic               ext_reset_n_i = 1'b1;
  logic               press         = 1'b1;  // Request held low from the start.
  mps_supply_type     supply_i      = 2'h1;  // Supply below the lower threshold.
  mps_cmd_type        cmd_i         = 2'h0;
  mps_ack_type        ack_i         = 2'h0;
  wire logic          power_on_request_n_i;
  logic               pon_pullup_en_o, core_reset_n_o, pins_tristate_o, ready_o;
  logic               save_req_o, detach_req_o, pon_held_o;
  logic [NUM_REG-1:0] reg_en_o;
  logic [NUM_IF-1:0]  if_cfg_o;
  int                 error_cnt     = 0;
  int                 n_compared    = 0;

  // Small step counts keep the run short.
  mps_sequencer #(.REG_STEP(2), .RST_HOLD(4)) dut_u (.ref_clk_i, .rst_i, .power_on_request_n_i, .supply_i,
    .ext_reset_n_i, .cmd_i, .ack_i, .pon_pullup_en_o, .reg_en_o, .core_reset_n_o, .pins_tristate_o,
    .if_cfg_o, .ready_o, .save_req_o, .detach_req_o, .pon_held_o);
  mps_host_model host_u (.ref_clk_i, .press_i(press), .pullup_en_i(pon_pullup_en_o),
    .request_n_o(power_on_request_n_i));

  initial
    forever #12.5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Bounded wait on a level; running out of time ends the run.
  task automatic wait_lv(input string nm, ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(nm, s, v);
    if (n == 400)
      report_and_stop();
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_reset();
    chk("reg_en", reg_en_o, 4'h0);
    chk("tristate", pins_tristate_o, 1'b1);
    chk("pullup", pon_pullup_en_o, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_supply_rise();
    supply_i = 2'h2;
    wait_lv("ready", ready_o, 1'b1);
    chk("if_cfg", if_cfg_o, 4'hf);
    chk("reg_en", reg_en_o, 4'hf);
    chk("tristate", pins_tristate_o, 1'b0);
    chk("pon_held", pon_held_o, 1'b0);
    press = 1'b0;
    $display("test supply rise done");
  endtask

  task automatic t_ignore();
    cyc(30);
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    cyc(60);
    chk("ready", ready_o, 1'b1);
    $display("test ignore done");
  endtask

  task automatic t_power_off();
    cmd_i = 2'h2;
    cyc(1);
    cmd_i = 2'h0;
    wait_lv("save", save_req_o, 1'b1);
    cyc(5);
    chk("detach", detach_req_o, 1'b0);
    ack_i = 2'h2;
    cyc(1);
    ack_i = 2'h0;
    wait_lv("detach", detach_req_o, 1'b1);
    ack_i = 2'h1;
    cyc(1);
    ack_i = 2'h0;
    wait_lv("tristate", pins_tristate_o, 1'b1);
    cyc(10);
    chk("reg_en", reg_en_o, 4'h0);
    chk("tristate", pins_tristate_o, 1'b1);
    $display("test power off done");
  endtask

  task automatic t_press_on();
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    wait_lv("ready", ready_o, 1'b1);
    $display("test press on done");
  endtask

  task automatic t_soft_reset();
    cyc(40);
    cmd_i = 2'h1;
    cyc(1);
    cmd_i = 2'h0;
    wait_lv("core_rst", core_reset_n_o, 1'b0);
    chk("reg_en", reg_en_o, 4'hf);
    wait_lv("ready", ready_o, 1'b1);
    $display("test soft reset done");
  endtask

  task automatic t_ext_reset();
    ext_reset_n_i = 1'b0;
    wait_lv("core_rst", core_reset_n_o, 1'b0);
    ext_reset_n_i = 1'b1;
    wait_lv("ready", ready_o, 1'b1);
    $display("test ext reset done");
  endtask

  task automatic t_supply_loss();
    supply_i = 2'h1;
    wait_lv("tristate", pins_tristate_o, 1'b1);
    cyc(4);
    chk("reg_en", reg_en_o, 4'h0);
    chk("save", save_req_o, 1'b0);
    chk("detach", detach_req_o, 1'b0);
    $display("test supply loss done");
  endtask

  // Supply returns with the request released: the module must stay off until a press.
  task automatic t_off_hold();
    supply_i = 2'h2;
    cyc(40);
    chk("ready", ready_o, 1'b0);
    chk("reg_en", reg_en_o, 4'h0);
    chk("tristate", pins_tristate_o, 1'b1);
    press = 1'b1;
    cyc(1);
    press = 1'b0;
    wait_lv("ready", ready_o, 1'b1);
    $display("test off hold done");
  endtask

  // Reset for three edges, then the scenarios in order; each but reset, power off and supply loss leaves the module ready for the next.
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_supply_rise();
    t_ignore();
    t_power_off();
    t_press_on();
    t_soft_reset();
    t_ext_reset();
    t_supply_loss();
    t_off_hold();
    report_and_stop();
  end
endmodule
